// ---- common/quad_pkg.sv ----
package quad_pkg;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int POS_W = 32;
    localparam logic [31:0] POS_RESET = 32'h0000_0000;
    localparam logic [31:0] LIMIT_RESET = 32'hffff_ffff;

    // ------------------------------------------------------------
    // Setting encodings
    // ------------------------------------------------------------
    localparam logic SIG_QUADRATURE = 1'h0;
    localparam logic SIG_STEP_DIR = 1'h1;
    localparam logic EDGE_BOTH = 1'h1;
    localparam logic EDGE_A_ONLY = 1'h0;
    localparam logic INDEX_RESET_ON = 1'h1;

    // Settings as one group.
    typedef struct packed {
        logic signalling_select;
        logic edge_count_select;
        logic index_reset_select;
    } encoder_control_s;

    // Synchronised encoder pins.
    typedef struct packed {
        logic phase_a;
        logic phase_b;
        logic index;
    } enc_pins_s;

endpackage

// ---- logic/pin_sync.sv ----
`timescale 1ns/100ps
module pin_sync (
    input wire logic ref_clk, // System clock.
    input wire logic reset, // Asynchronous reset, active high.
    input wire quad_pkg::enc_pins_s pins_raw, // Pins from outside.
    output quad_pkg::enc_pins_s pins_sync // Pins after two stages.
);

    typedef struct packed {
        quad_pkg::enc_pins_s first;
        quad_pkg::enc_pins_s second;
    } sync_state_s;

    sync_state_s state_reg;
    sync_state_s state_next;

    // ------------------------------------------------------------
    // Two flip-flop synchroniser
    // ------------------------------------------------------------

    // The first stage feeds only the second to keep metastability out.
    always_comb begin
        state_next = state_reg;
        state_next.first = pins_raw;
        state_next.second = state_reg.first;
    end

    // Registers the stages.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pins_sync = state_reg.second;

endmodule

// ---- logic/quadrature_position_counter.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// - With index reset off, an index pulse leaves the position as is.
// - With index reset off, the position resets only on a forward step from the limit.
// - Signalling select 0 takes the pins as quadrature phases.
// - In quadrature with edge select 1, an edge of either phase counts unless both phases change at once.
// - With edge select 0, only edges of phase A count.
// - The position is signed and steps up forward and down in reverse.
module quadrature_position_counter (
    input wire logic ref_clk, // System clock, 100 MHz.
    input wire logic reset, // Asynchronous reset, active high.
    input wire logic phase_a_input, // Encoder phase A pin.
    input wire logic phase_b_input, // Encoder phase B pin, or direction.
    input wire logic index_input, // Encoder index pin, active high.
    input wire quad_pkg::encoder_control_s encoder_control, // Settings.
    input wire logic [31:0] position_limit, // Top of the count.
    output logic signed [31:0] position_value, // Current position.
    output logic direction, // 1 while last step was reverse.
    output logic index_seen // One-cycle pulse on an index edge.
);

    typedef struct packed {
        quad_pkg::enc_pins_s prev;
        logic signed [31:0] pos;
        logic dir;
        logic idx;
    } count_state_s;

    count_state_s state_reg;
    count_state_s state_next;
    quad_pkg::enc_pins_s pins;
    quad_pkg::enc_pins_s raw;

    assign raw = '{phase_a: phase_a_input, phase_b: phase_b_input,
                   index: index_input};

    // ------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------

    pin_sync u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .pins_raw(raw),
        .pins_sync(pins)
    );

    // ------------------------------------------------------------
    // Counting logic
    // ------------------------------------------------------------

    // Steps the position by one edge; a forward step from the limit wraps to 0.
    function automatic logic signed [31:0] step_pos(
        input logic signed [31:0] pos,
        input logic rev,
        input logic [31:0] limit
    );
        logic signed [31:0] res;
        if (!rev) begin
            if (pos == $signed(limit)) begin
                res = quad_pkg::POS_RESET;
            end else begin
                res = pos + 32'sd1;
            end
        end else begin
            res = pos - 32'sd1;
        end
        return res;
    endfunction

    // Decodes edges and direction; index clearing takes priority.
    always_comb begin
        logic a_edge;
        logic b_edge;
        logic count;
        logic rev;
        logic idx_edge;
        a_edge = pins.phase_a ^ state_reg.prev.phase_a;
        b_edge = pins.phase_b ^ state_reg.prev.phase_b;
        idx_edge = pins.index & ~state_reg.prev.index;
        count = 1'b0;
        rev = state_reg.dir;
        state_next = state_reg;
        state_next.prev = pins;
        state_next.idx = idx_edge;
        if (encoder_control.signalling_select == quad_pkg::SIG_QUADRATURE)
        begin
            // Direction from relative phase: A leads B is forward.
            if (a_edge && !b_edge) begin
                count = 1'b1;
                rev = pins.phase_a == pins.phase_b;
            end else if (b_edge && !a_edge) begin
                // B edges count only at full resolution.
                count = encoder_control.edge_count_select
                        == quad_pkg::EDGE_BOTH;
                rev = pins.phase_a != pins.phase_b;
            end
        end else begin
            // Step and direction: A rising counts, B gives direction.
            count = a_edge && pins.phase_a;
            rev = pins.phase_b;
        end
        if (count) begin
            state_next.pos = step_pos(state_reg.pos, rev, position_limit);
            state_next.dir = rev;
        end
        // Index ignored unless index reset is selected.
        if (idx_edge && encoder_control.index_reset_select
                == quad_pkg::INDEX_RESET_ON) begin
            state_next.pos = quad_pkg::POS_RESET;
        end
    end

    // Registers the state.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign position_value = state_reg.pos;
    assign direction = state_reg.dir;
    assign index_seen = state_reg.idx;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    AST_IDX_IGNORED: assert property (@(posedge ref_clk) disable iff (reset)
        state_next.idx && !encoder_control.index_reset_select
        && !$changed(pins.phase_a) && !$changed(pins.phase_b)
        |=> $stable(position_value))
        else $error("Position moved on ignored index.");
    AST_IDX_CLEAR: assert property (@(posedge ref_clk) disable iff (reset)
        state_next.idx && encoder_control.index_reset_select
        |=> position_value == 0)
        else $error("Index did not clear position.");
    AST_WRAP: assert property (@(posedge ref_clk) disable iff (reset)
        !state_next.idx && state_next.pos != state_reg.pos
        && !state_next.dir && state_reg.pos == $signed(position_limit)
        |=> position_value == 0)
        else $error("No wrap at limit.");
    AST_A_ONLY: assert property (@(posedge ref_clk) disable iff (reset)
        !encoder_control.signalling_select
        && !encoder_control.edge_count_select && !state_next.idx
        && $changed(pins.phase_b) && !$changed(pins.phase_a)
        |=> $stable(position_value))
        else $error("Phase B edge counted at half resolution.");
    AST_BOTH: assert property (@(posedge ref_clk) disable iff (reset)
        !encoder_control.signalling_select
        && encoder_control.edge_count_select && !state_next.idx
        && ($changed(pins.phase_a) ^ $changed(pins.phase_b))
        |=> $changed(position_value))
        else $error("Edge not counted at full resolution.");
    AST_REV: assert property (@(posedge ref_clk) disable iff (reset)
        !encoder_control.signalling_select && !state_next.idx
        && $changed(pins.phase_b) && !$changed(pins.phase_a)
        && encoder_control.edge_count_select
        && (pins.phase_a != pins.phase_b)
        |=> position_value == $past(position_value) - 1)
        else $error("Reverse step not decremented.");
    AST_FWD: assert property (@(posedge ref_clk) disable iff (reset)
        !encoder_control.signalling_select && !state_next.idx
        && $changed(pins.phase_a) && !$changed(pins.phase_b)
        && (pins.phase_a != pins.phase_b)
        && state_reg.pos != $signed(position_limit)
        |=> position_value == $past(position_value) + 1)
        else $error("Forward step not incremented.");
    AST_IDX_PULSE: assert property (@(posedge ref_clk) disable iff (reset)
        index_seen |=> !index_seen)
        else $error("Index pulse longer than one cycle.");

    // Quiet pins must never move the count, whatever the mode.
    AST_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
        !state_next.idx && !$changed(pins.phase_a)
        && !$changed(pins.phase_b)
        |=> $stable(position_value))
        else $error("Position moved with quiet pins.");
    // In quadrature, both phases moving at once has no direction, so it is dropped.
    AST_SIMUL: assert property (@(posedge ref_clk) disable iff (reset)
        !encoder_control.signalling_select && !state_next.idx
        && $changed(pins.phase_a) && $changed(pins.phase_b)
        |=> $stable(position_value))
        else $error("Double phase change was counted.");
    // At half resolution a forward phase A edge still counts.
    AST_A_HALF: assert property (@(posedge ref_clk) disable iff (reset)
        !encoder_control.signalling_select
        && !encoder_control.edge_count_select && !state_next.idx
        && $changed(pins.phase_a) && !$changed(pins.phase_b)
        && (pins.phase_a != pins.phase_b)
        && state_reg.pos != $signed(position_limit)
        |=> position_value == $past(position_value) + 1)
        else $error("Phase A edge not counted at half resolution.");

    COV_REVERSE: cover property (@(posedge ref_clk) disable iff (reset)
        direction && $changed(position_value));
    COV_WRAP: cover property (@(posedge ref_clk) disable iff (reset)
        $past(position_value) != 0 && position_value == 0 && !index_seen);
    COV_INDEX: cover property (@(posedge ref_clk) disable iff (reset)
        index_seen && encoder_control.index_reset_select);

endmodule

// ---- testbench/encoder_model.sv ----
`timescale 1ns/100ps
// ------------------------------------------------------------
// Incremental encoder with index
// ------------------------------------------------------------
module encoder_model (
    input wire logic ref_clk, // System clock.
    input wire logic step_en, // Move one Gray state.
    input wire logic step_rev, // 1 moves in reverse.
    input wire logic idx_en, // Raise the index for one cycle.
    output logic phase_a, // Phase A pin.
    output logic phase_b, // Phase B pin.
    output logic index // Index pin.
);
    logic [1:0] gray_reg = 2'h0;

    // A real encoder only moves one Gray state at a time, so the two
    // phases never change together; pins move just after a rising edge.
    always_ff @(posedge ref_clk) begin
        if (step_en) begin
            gray_reg <= step_rev ? gray_reg - 2'h1 : gray_reg + 2'h1;
        end
        index <= idx_en;
    end

    // Forward order of the pins is 00, 10, 11, 01.
    assign phase_a = gray_reg[1] ^ gray_reg[0];
    assign phase_b = gray_reg[1];
endmodule

// ---- testbench/quadrature_position_counter_tb.sv ----
`timescale 1ns/100ps
module quadrature_position_counter_tb;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic step_en = 1'b0;
    logic step_rev = 1'b0;
    logic idx_en = 1'b0;
    logic pa, pb, pi, dir, seen;
    logic signed [31:0] pos;
    quad_pkg::encoder_control_s ctl = '0;
    logic [31:0] limit = quad_pkg::LIMIT_RESET;
    logic [31:0] exp_pos = 32'h0;
    logic [1:0] gray = 2'h0;
    logic [31:0] rng = 32'h0001_786c;
    int mismatches = 0;
    int tests_run = 0;

    // ------------------------------------------------------------
    // Clock, parts and watchdog
    // ------------------------------------------------------------
    initial forever #5 ref_clk = ~ref_clk;

    encoder_model u_enc (.ref_clk(ref_clk), .step_en(step_en),
        .step_rev(step_rev), .idx_en(idx_en), .phase_a(pa),
        .phase_b(pb), .index(pi));

    quadrature_position_counter u_dut (.ref_clk(ref_clk), .reset(reset),
        .phase_a_input(pa), .phase_b_input(pb), .index_input(pi),
        .encoder_control(ctl), .position_limit(limit),
        .position_value(pos), .direction(dir), .index_seen(seen));

    // The 124 steps of 6 cycles each need far less than this.
    initial begin
        #50us;
        mismatches++;
        test_done();
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Signed step; a forward step from the limit wraps to zero.
    function automatic logic [31:0] next_pos(input logic [31:0] p,
        input logic rev);
        if (!rev && p == limit) return 32'h0;
        return rev ? p - 32'h1 : p + 32'h1;
    endfunction

    task automatic check(input string name, input logic [31:0] got,
        input logic [31:0] want);
        tests_run++;
        if (got !== want) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, want, got);
        end
    endtask

    task automatic test_done();
        if (mismatches == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // One encoder step with an optional index pulse, then compare.
    task automatic act(input logic rev, input logic idx);
        logic cnt;
        logic clr;
        cnt = ctl.edge_count_select | (rev ? gray[0] : ~gray[0]);
        clr = idx & ctl.index_reset_select;
        @(negedge ref_clk);
        step_en = 1'b1;
        step_rev = rev;
        idx_en = idx;
        @(negedge ref_clk);
        step_en = 1'b0;
        idx_en = 1'b0;
        gray = rev ? gray - 2'h1 : gray + 2'h1;
        if (clr) exp_pos = 32'h0;
        else if (cnt) exp_pos = next_pos(exp_pos, rev);
        repeat (3) @(negedge ref_clk);
        check("index_seen", {31'h0, seen}, {31'h0, idx});
        @(negedge ref_clk);
        check("position_value", pos, exp_pos);
        if (cnt && !clr) begin
            check("direction", {31'h0, dir}, {31'h0, rev});
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        check("position_value", pos, 32'h0);
        reset = 1'b0;
        // Reverse, one forward, reverse again must track exactly.
        act(1'b1, 1'b0);
        act(1'b1, 1'b0);
        act(1'b0, 1'b0);
        act(1'b1, 1'b1);
        act(1'b1, 1'b0);
        // Clear by index, then count up to a small limit.
        ctl.index_reset_select = 1'b1;
        act(1'b1, 1'b1);
        ctl.index_reset_select = 1'b0;
        limit = 32'h3;
        repeat (6) act(1'b0, 1'b0);
        for (int c = 0; c < 4; c++) begin
            ctl.edge_count_select = c[0];
            ctl.index_reset_select = c[1];
            limit = (c == 2) ? 32'h2 : quad_pkg::LIMIT_RESET;
            repeat (28) begin
                rng = xs(rng);
                act(rng[0], rng[6:4] == 3'h0);
            end
        end
        test_done();
    end
endmodule
